// >>> servo_alarm_handler.v
// Servo driver alarm latch, code output remap, LED blink, history and clear logic
`timescale 1ns/100ps
`include "alarm_map.vh"
module servo_alarm_handler #(
  parameter [25:0] BLINK_ON_CYC = `BLINK_ON_MS * `CLK_KHZ,
  parameter [25:0] BLINK_OFF_CYC = `BLINK_OFF_MS * `CLK_KHZ,
  parameter [25:0] BLINK_GAP_CYC = `BLINK_GAP_MS * `CLK_KHZ,
  parameter [11:0] CUT_CURRENT_MASK = 12'hfff
) (
  input wire mclk,
  input wire srst,
  input wire [11:0] fault_in,
  input wire [3:0] warn_in,
  input wire position_mode,
  input wire position_request_in,
  input wire shared_clear_input,
  input wire ready_in,
  input wire limit_reached_in,
  input wire index_near_zero_in,
  input wire [2:0] position_data_in,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [15:0] rdata,
  output reg alarm_status_out,
  output reg motor_stop,
  output reg motor_current_off,
  output reg brake_engage,
  output wire alarm_led,
  output reg ready_out,
  output reg limit_reached_out,
  output reg index_near_zero_out,
  output reg position_clock_in,
  output reg warning_out,
  output reg irq
);

// Per-cause entry: {resettable, blinks[2:0], code bits[2:0], code[7:0]}
function [14:0] cause_info;
  input [3:0] idx;
  begin
    case (idx)
      4'h0: cause_info = {1'b1, `BLINK_G2, 3'b010, `CODE_OVERHEAT};
      4'h1: cause_info = {1'b0, `BLINK_G2, 3'b010, `CODE_MOTOR_HOT};
      4'h2: cause_info = {1'b1, `BLINK_G2, 3'b010, `CODE_OVERLOAD};
      4'h3: cause_info = {1'b1, `BLINK_G2, 3'b010, `CODE_OVERSPEED};
      4'h4: cause_info = {1'b1, `BLINK_G2, 3'b010, `CODE_PULSE_ERR};
      4'h5: cause_info = {1'b0, `BLINK_G3, 3'b011, `CODE_REGEN_HOT};
      4'h6: cause_info = {1'b0, `BLINK_G3, 3'b011, `CODE_OVERVOLT};
      4'h7: cause_info = {1'b1, `BLINK_G3, 3'b011, `CODE_MAIN_PWR};
      4'h8: cause_info = {1'b1, `BLINK_G3, 3'b011, `CODE_UNDERVOLT};
      4'h9: cause_info = {1'b1, `BLINK_G4, 3'b100, `CODE_DEVIATION};
      4'ha: cause_info = {1'b0, `BLINK_G5, 3'b101, `CODE_OVERCURR};
      4'hb: cause_info = {1'b1, `BLINK_ABS, 3'b111, `CODE_ABS_LOSS};
      default: cause_info = 15'h0;
    endcase
  end
endfunction

wire pos_req_s;
wire clear_s;

sync2 #(.WIDTH(2)) u_pin_sync (
  .mclk(mclk),
  .srst(srst),
  .d({position_request_in, shared_clear_input}),
  .q({pos_req_s, clear_s})
);

reg active_reg;
reg [3:0] cause_reg;
reg [7:0] ctrl_reg;
reg abs_arm_reg;
reg clear_prev_reg;
reg [2:0] int_stat_reg;
reg [2:0] int_mask_reg;
reg [3:0] warn_prev_reg;
reg [7:0] hist_mem [0:`HIST_DEPTH-1];
reg [3:0] hist_cnt_reg;
reg [3:0] new_cause;
reg any_fault;
reg [15:0] rdata_next;
integer i;

wire [14:0] info = cause_info(cause_reg);
wire [14:0] new_info = cause_info(new_cause);
wire pos_out_active = position_mode & pos_req_s;
wire cmd_wr = wr_en && (addr == `ADDR_CMD);
wire tool_reset = cmd_wr & wdata[`CMD_RESET];
// Falling edge only; the rising edge is deliberately ignored
wire pin_reset = clear_prev_reg & ~clear_s & ~pos_out_active;
wire any_reset = pin_reset | tool_reset;
wire is_abs = (cause_reg == `CAUSE_ABS);
// Non-resettable causes only leave through srst, never through a pin or tool reset
wire clear_now = active_reg & info[14] & any_reset & (~is_abs | abs_arm_reg);
wire raise_now = ~active_reg & any_fault;
wire warn_rise = |(warn_in & ~warn_prev_reg);
wire [2:0] int_event = {clear_now, warn_rise, raise_now};

// Lowest index wins when several causes appear together
always @*
begin
  new_cause = 4'h0;
  any_fault = 1'b0;
  for (i = `NUM_CAUSE - 1; i >= 0; i = i - 1)
  begin
    if (fault_in[i])
    begin
      new_cause = i[3:0];
      any_fault = 1'b1;
    end
  end
end

always @(posedge mclk)
begin
  if (srst)
  begin
    active_reg <= 1'b0;
    cause_reg <= 4'h0;
    abs_arm_reg <= 1'b0;
    hist_cnt_reg <= 4'h0;
  end
  else
  begin
    // Latched: the fault input going away does not release it
    if (raise_now)
    begin
      active_reg <= 1'b1;
      cause_reg <= new_cause;
    end
    else if (clear_now)
      active_reg <= 1'b0;
    if (cmd_wr && wdata[`CMD_ABS_ARM])
      abs_arm_reg <= 1'b1;
    else if (clear_now)
      abs_arm_reg <= 1'b0;
    if (cmd_wr && wdata[`CMD_HIST_CLR])
      hist_cnt_reg <= 4'h0;
    else if (raise_now && hist_cnt_reg != `HIST_DEPTH)
      hist_cnt_reg <= hist_cnt_reg + 4'h1;
  end
end

// Newest at index 0; oldest drops off the end
always @(posedge mclk)
begin
  if (raise_now)
  begin
    hist_mem[0] <= new_info[7:0];
    for (i = 1; i < `HIST_DEPTH; i = i + 1)
      hist_mem[i] <= hist_mem[i-1];
  end
end

always @(posedge mclk)
begin
  if (srst)
  begin
    alarm_status_out <= 1'b0;
    motor_stop <= 1'b1;
    motor_current_off <= 1'b0;
    brake_engage <= 1'b0;
    ready_out <= 1'b0;
    limit_reached_out <= 1'b0;
    index_near_zero_out <= 1'b0;
    position_clock_in <= 1'b0;
    warning_out <= 1'b0;
    clear_prev_reg <= 1'b0;
    warn_prev_reg <= 4'h0;
  end
  else
  begin
    clear_prev_reg <= clear_s;
    warn_prev_reg <= warn_in;
    alarm_status_out <= ~active_reg;
    motor_stop <= active_reg;
    motor_current_off <= active_reg & CUT_CURRENT_MASK[cause_reg];
    brake_engage <= active_reg & CUT_CURRENT_MASK[cause_reg];
    warning_out <= |warn_in;
    position_clock_in <= pos_out_active & clear_s;
    if (pos_out_active)
    begin
      ready_out <= position_data_in[0];
      limit_reached_out <= position_data_in[1];
      index_near_zero_out <= position_data_in[2];
    end
    else if (ctrl_reg[`CTRL_CODE_EN])
    begin
      ready_out <= active_reg & info[8];
      limit_reached_out <= active_reg & info[9];
      index_near_zero_out <= active_reg & info[10];
    end
    else
    begin
      ready_out <= ready_in & ~active_reg;
      limit_reached_out <= limit_reached_in;
      index_near_zero_out <= index_near_zero_in;
    end
  end
end

led_blinker #(
  .ON_CYC(BLINK_ON_CYC),
  .OFF_CYC(BLINK_OFF_CYC),
  .GAP_CYC(BLINK_GAP_CYC)
) u_blinker (
  .mclk(mclk),
  .srst(srst),
  .enable(active_reg),
  .count(info[13:11]),
  .led(alarm_led)
);

// Tool register port; status bits set wins over a write-one clear
always @(posedge mclk)
begin
  if (srst)
  begin
    ctrl_reg <= `CTRL_RST;
    int_mask_reg <= `INT_MASK_RST;
    int_stat_reg <= 3'h0;
    irq <= 1'b0;
  end
  else
  begin
    if (wr_en && addr == `ADDR_CTRL)
      ctrl_reg <= wdata[7:0];
    if (wr_en && addr == `ADDR_INT_MASK)
      int_mask_reg <= wdata[2:0];
    if (wr_en && addr == `ADDR_INT_STAT)
      int_stat_reg <= (int_stat_reg & ~wdata[2:0]) | int_event;
    else
      int_stat_reg <= int_stat_reg | int_event;
    irq <= |(int_stat_reg & int_mask_reg);
  end
end

always @*
begin
  rdata_next = 16'h0;
  if (addr == `ADDR_CTRL)
    rdata_next = {8'h0, ctrl_reg};
  else if (addr == `ADDR_ACTIVE)
    rdata_next = {7'h0, active_reg, (active_reg ? info[7:0] : 8'h0)};
  else if (addr == `ADDR_INT_STAT)
    rdata_next = {13'h0, int_stat_reg};
  else if (addr == `ADDR_INT_MASK)
    rdata_next = {13'h0, int_mask_reg};
  else if (addr == `ADDR_HIST_CNT)
    rdata_next = {12'h0, hist_cnt_reg};
  else if (addr >= `ADDR_HIST_BASE && addr < `ADDR_HIST_BASE + `HIST_DEPTH)
  begin
    if (addr - `ADDR_HIST_BASE < {4'h0, hist_cnt_reg})
      rdata_next = {8'h0, hist_mem[addr[3:0]]};
  end
end

always @(posedge mclk)
begin
  if (srst)
    rdata <= 16'h0;
  else if (rd_en)
    rdata <= rdata_next;
  else
    rdata <= 16'h0;
end

endmodule

// >>> alarm_map.vh
// Register offsets, field positions, alarm table values and timing for the alarm handler
`ifndef ALARM_MAP_VH
`define ALARM_MAP_VH

// Register word addresses on the tool port
`define ADDR_CTRL 8'h00
`define ADDR_ACTIVE 8'h01
`define ADDR_CMD 8'h02
`define ADDR_INT_STAT 8'h03
`define ADDR_INT_MASK 8'h04
`define ADDR_HIST_CNT 8'h05
`define ADDR_HIST_BASE 8'h10

// Field positions
`define CTRL_CODE_EN 0
`define CMD_RESET 0
`define CMD_HIST_CLR 1
`define CMD_ABS_ARM 2
`define INT_RAISED 0
`define INT_WARN 1
`define INT_CLEARED 2
`define ACTIVE_FLAG 8

// Reset values
`define CTRL_RST 8'h00
`define INT_MASK_RST 3'h0

// Alarm sources and history
`define NUM_CAUSE 12
`define CAUSE_ABS 4'hb
`define HIST_DEPTH 10
`define NUM_WARN 4

// Alarm codes
`define CODE_OVERHEAT 8'h21
`define CODE_MOTOR_HOT 8'h26
`define CODE_OVERLOAD 8'h30
`define CODE_OVERSPEED 8'h31
`define CODE_PULSE_ERR 8'h34
`define CODE_REGEN_HOT 8'h51
`define CODE_OVERVOLT 8'h22
`define CODE_MAIN_PWR 8'h23
`define CODE_UNDERVOLT 8'h25
`define CODE_DEVIATION 8'h10
`define CODE_OVERCURR 8'h20
`define CODE_ABS_LOSS 8'h60

// Blink counts per group
`define BLINK_G2 3'h2
`define BLINK_G3 3'h3
`define BLINK_G4 3'h4
`define BLINK_G5 3'h5
`define BLINK_ABS 3'h7

// Blink timing
`define CLK_KHZ 25000
`define BLINK_ON_MS 200
`define BLINK_OFF_MS 200
`define BLINK_GAP_MS 1200

`endif

// >>> sync2.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module sync2 #(
  parameter WIDTH = 1
) (
  input wire mclk,
  input wire srst,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

reg [WIDTH-1:0] meta_reg;

always @(posedge mclk)
begin
  if (srst)
  begin
    meta_reg <= {WIDTH{1'b0}};
    q <= {WIDTH{1'b0}};
  end
  else
  begin
    meta_reg <= d;
    q <= meta_reg;
  end
end

endmodule

// >>> led_blinker.v
// Fault LED blinker: groups of N flashes separated by a long pause
`timescale 1ns/100ps
module led_blinker #(
  parameter [25:0] ON_CYC = 26'd5000000,
  parameter [25:0] OFF_CYC = 26'd5000000,
  parameter [25:0] GAP_CYC = 26'd30000000
) (
  input wire mclk,
  input wire srst,
  input wire enable,
  input wire [2:0] count,
  output reg led
);

localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_ON = 2'd1;
localparam [1:0] ST_OFF = 2'd2;
localparam [1:0] ST_GAP = 2'd3;

reg [1:0] state_reg;
reg [25:0] timer_reg;
reg [2:0] flash_reg;

always @(posedge mclk)
begin
  if (srst || !enable)
  begin
    state_reg <= ST_IDLE;
    timer_reg <= 26'h0;
    flash_reg <= 3'h0;
    led <= 1'b0;
  end
  else
  begin
    timer_reg <= timer_reg + 26'h1;
    case (state_reg)
      ST_IDLE:
      begin
        state_reg <= ST_ON;
        timer_reg <= 26'h0;
        flash_reg <= 3'h1;
        led <= 1'b1;
      end
      ST_ON:
        if (timer_reg == ON_CYC - 26'h1)
        begin
          led <= 1'b0;
          timer_reg <= 26'h0;
          state_reg <= (flash_reg == count) ? ST_GAP : ST_OFF;
        end
      ST_OFF:
        if (timer_reg == OFF_CYC - 26'h1)
        begin
          led <= 1'b1;
          timer_reg <= 26'h0;
          flash_reg <= flash_reg + 3'h1;
          state_reg <= ST_ON;
        end
      ST_GAP:
        if (timer_reg == GAP_CYC - 26'h1)
          state_reg <= ST_IDLE;
      default:
        state_reg <= ST_IDLE;
    endcase
  end
end

endmodule

// >>> servo_alarm_props.sv
// Port-level checks for the servo alarm handler
`timescale 1ns/100ps
module servo_alarm_props (
  input wire mclk,
  input wire srst,
  input wire [11:0] fault_in,
  input wire [3:0] warn_in,
  input wire position_mode,
  input wire position_request_in,
  input wire [2:0] position_data_in,
  input wire rd_en,
  input wire [15:0] rdata,
  input wire alarm_status_out,
  input wire motor_stop,
  input wire motor_current_off,
  input wire brake_engage,
  input wire alarm_led,
  input wire ready_out,
  input wire limit_reached_out,
  input wire index_near_zero_out,
  input wire warning_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  alarm_drop_a: assert property ($rose(|fault_in) && alarm_status_out |-> ##2 !alarm_status_out)
    else $error("alarm status stayed on after a fault");
  stop_pair_a: assert property (alarm_status_out != motor_stop)
    else $error("motor stop disagrees with alarm status");
  current_cut_a: assert property ($past(srst) || motor_current_off == motor_stop)
    else $error("motor current not cut during alarm");
  brake_hold_a: assert property (brake_engage |-> motor_current_off)
    else $error("brake engaged with motor energised");
  rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 16'h0000)
    else $error("read data outside the answer cycle");
  warn_follow_a: assert property (warning_out == $past(|warn_in))
    else $error("warning output does not follow warnings");
  pos_wins_a: assert property ((position_mode && position_request_in && $stable(position_data_in)) [*5]
    |-> {index_near_zero_out, limit_reached_out, ready_out} == position_data_in)
    else $error("position output lost priority");
  led_dark_a: assert property (alarm_status_out [*3] |-> !alarm_led)
    else $error("led lit without an alarm");
endmodule

// >>> host_io.sv
// Host controller model driving the discrete input pins
`timescale 1ns/100ps
module host_io (
  input wire mclk,
  input wire clr_go,
  input wire req_lvl,
  output reg shared_clear_input,
  output reg position_request_in
);
  reg [2:0] hold_cnt;
  initial
  begin
    shared_clear_input = 1'b0;
    position_request_in = 1'b0;
    hold_cnt = 3'h0;
  end
  // Always a whole ON then OFF pulse, several cycles wide so the rising edge shows alone
  always @(posedge mclk)
  begin
    if (clr_go)
      hold_cnt <= 3'h6;
    else if (hold_cnt != 3'h0)
      hold_cnt <= hold_cnt - 3'h1;
    shared_clear_input <= clr_go || hold_cnt > 3'h1;
    position_request_in <= req_lvl;
  end
endmodule

// >>> test_servo_alarm_handler.sv
// Self-checking bench for the servo alarm handler
`timescale 1ns/100ps
`include "alarm_map.vh"
module test_servo_alarm_handler;
  reg mclk = 1'b0;
  reg srst = 1'b1;
  reg [11:0] fault_in = 12'h000;
  reg [3:0] warn_in = 4'h0;
  reg position_mode = 1'b0;
  reg req_lvl = 1'b0;
  reg clr_go = 1'b0;
  reg ready_in = 1'b1;
  reg limit_reached_in = 1'b0;
  reg index_near_zero_in = 1'b0;
  reg [2:0] position_data_in = 3'h0;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  wire shared_clear_input, position_request_in, alarm_status_out, motor_stop, motor_current_off;
  wire brake_engage, alarm_led, ready_out, limit_reached_out, index_near_zero_out, position_clock_in;
  wire warning_out, irq;
  wire [15:0] rdata;
  integer error_cnt = 0;
  integer comparisons = 0;
  integer n;
  reg [15:0] v;
  always #20 mclk = ~mclk;
  host_io host_u (.mclk(mclk), .clr_go(clr_go), .req_lvl(req_lvl), .shared_clear_input(shared_clear_input),
    .position_request_in(position_request_in));
  // Short blink timing keeps a group within a few dozen cycles
  servo_alarm_handler #(.BLINK_ON_CYC(26'd4), .BLINK_OFF_CYC(26'd4), .BLINK_GAP_CYC(26'd12)) dut_u (
    .mclk(mclk), .srst(srst), .fault_in(fault_in), .warn_in(warn_in), .position_mode(position_mode),
    .position_request_in(position_request_in), .shared_clear_input(shared_clear_input), .ready_in(ready_in),
    .limit_reached_in(limit_reached_in), .index_near_zero_in(index_near_zero_in),
    .position_data_in(position_data_in), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .alarm_status_out(alarm_status_out), .motor_stop(motor_stop),
    .motor_current_off(motor_current_off), .brake_engage(brake_engage), .alarm_led(alarm_led),
    .ready_out(ready_out), .limit_reached_out(limit_reached_out), .index_near_zero_out(index_near_zero_out),
    .position_clock_in(position_clock_in), .warning_out(warning_out), .irq(irq));
  task finish_test;
    begin
      $display("errors %0d, comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      @(negedge mclk);
      v = rdata;
    end
  endtask
  task wait_st(input lvl);
    integer i;
    begin
      for (i = 0; i < 40 && alarm_status_out !== lvl; i = i + 1)
        @(negedge mclk);
      chk(alarm_status_out, lvl);
      if (alarm_status_out !== lvl)
        finish_test;
    end
  endtask
  // Fault held only until latched, so later checks see a cause already gone
  task raise(input [3:0] idx);
    begin
      @(posedge mclk);
      fault_in <= 12'h001 << idx;
      wait_st(1'b0);
      @(posedge mclk);
      fault_in <= 12'h000;
      repeat (10) @(negedge mclk);
      chk(alarm_status_out, 1'b0);
    end
  endtask
  task pulse;
    begin
      @(posedge mclk);
      clr_go <= 1'b1;
      @(posedge mclk);
      clr_go <= 1'b0;
    end
  endtask
  task blinks;
    integer i, low;
    reg prev;
    begin
      n = 0;
      low = 0;
      prev = 1'b0;
      for (i = 0; i < 400 && low < 10; i = i + 1)
      begin
        @(negedge mclk);
        low = alarm_led ? 0 : low + 1;
      end
      low = 0;
      for (i = 0; i < 400 && low < 10; i = i + 1)
      begin
        @(negedge mclk);
        if (alarm_led && !prev)
          n = n + 1;
        prev = alarm_led;
        low = alarm_led ? 0 : low + 1;
      end
    end
  endtask
  task t_reset;
    begin
      chk(alarm_status_out, 1'b1);
      rd(`ADDR_ACTIVE); chk(v, 16'h0000);
      rd(`ADDR_CTRL); chk(v, {8'h00, `CTRL_RST});
      rd(`ADDR_INT_MASK); chk(v, {13'h0000, `INT_MASK_RST});
      rd(8'h7f); chk(v, 16'h0000);
    end
  endtask
  task t_overvolt;
    begin
      wr(`ADDR_CTRL, 16'h0001);
      raise(4'h6);
      rd(`ADDR_ACTIVE); chk(v, {8'h01, `CODE_OVERVOLT});
      chk({index_near_zero_out, limit_reached_out, ready_out}, 3'h3);
      blinks; chk(n, 3);
      pulse;
      repeat (20) @(negedge mclk);
      chk(alarm_status_out, 1'b0);
      wr(`ADDR_CMD, 16'h0001);
      repeat (10) @(negedge mclk);
      chk(alarm_status_out, 1'b0);
      srst <= 1'b1;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      wait_st(1'b1);
    end
  endtask
  task t_pin;
    begin
      wr(`ADDR_INT_MASK, 16'h0001);
      wr(`ADDR_CMD, 16'h0002);
      raise(4'h0);
      chk(irq, 1'b1);
      pulse;
      repeat (4) @(negedge mclk);
      chk(alarm_status_out, 1'b0);
      wait_st(1'b1);
      wr(`ADDR_INT_STAT, 16'h0007);
      repeat (2) @(negedge mclk);
      chk(irq, 1'b0);
    end
  endtask
  task t_tool;
    begin
      raise(4'h2);
      wr(`ADDR_CMD, 16'h0001);
      wait_st(1'b1);
      rd(`ADDR_HIST_CNT); chk(v, 16'h0002);
      rd(`ADDR_HIST_BASE); chk(v, {8'h00, `CODE_OVERLOAD});
      rd(8'h11); chk(v, {8'h00, `CODE_OVERHEAT});
      rd(8'h12); chk(v, 16'h0000);
      wr(`ADDR_CMD, 16'h0002);
      rd(`ADDR_HIST_CNT); chk(v, 16'h0000);
    end
  endtask
  task t_abs;
    begin
      raise(4'hb);
      wr(`ADDR_CMD, 16'h0001);
      repeat (10) @(negedge mclk);
      chk(alarm_status_out, 1'b0);
      // Arming must land an edge before the reset command
      wr(`ADDR_CMD, 16'h0004);
      wr(`ADDR_CMD, 16'h0001);
      wait_st(1'b1);
    end
  endtask
  task t_pos;
    begin
      wr(`ADDR_CTRL, 16'h0001);
      @(posedge mclk);
      position_mode <= 1'b1;
      position_data_in <= 3'h5;
      raise(4'h9);
      chk({index_near_zero_out, limit_reached_out, ready_out}, 3'h4);
      @(posedge mclk);
      req_lvl <= 1'b1;
      repeat (8) @(negedge mclk);
      chk({index_near_zero_out, limit_reached_out, ready_out}, 3'h5);
      pulse;
      repeat (4) @(negedge mclk);
      chk(position_clock_in, 1'b1);
      repeat (16) @(negedge mclk);
      chk(alarm_status_out, 1'b0);
      @(posedge mclk);
      req_lvl <= 1'b0;
      repeat (6) @(negedge mclk);
      pulse;
      wait_st(1'b1);
      position_mode <= 1'b0;
    end
  endtask
  task t_warn;
    begin
      @(posedge mclk);
      warn_in <= 4'h2;
      repeat (2) @(negedge mclk);
      chk(warning_out, 1'b1);
      chk(alarm_status_out, 1'b1);
      @(posedge mclk);
      warn_in <= 4'h0;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    // Outputs leave their reset values one edge after release
    repeat (2) @(negedge mclk);
    t_reset;
    t_overvolt;
    t_pin;
    t_tool;
    t_abs;
    t_pos;
    t_warn;
    finish_test;
  end
endmodule
bind servo_alarm_handler servo_alarm_props chk_u (.mclk(mclk), .srst(srst), .fault_in(fault_in),
  .warn_in(warn_in), .position_mode(position_mode), .position_request_in(position_request_in),
  .position_data_in(position_data_in), .rd_en(rd_en), .rdata(rdata), .alarm_status_out(alarm_status_out),
  .motor_stop(motor_stop), .motor_current_off(motor_current_off), .brake_engage(brake_engage),
  .alarm_led(alarm_led), .ready_out(ready_out), .limit_reached_out(limit_reached_out),
  .index_near_zero_out(index_near_zero_out), .warning_out(warning_out));
